/* dcg_clock_gen.v */
// Clock generation of a dual-channel interpolating DAC with AHB-Lite registers.
// Assumes all clock and strap pins are sampled levels synchronous to hclk.
//
// Operation
// - Internal 1x to 16x clocks come from the PLL path or sample clock.
// - Strap low and dual bit clear select external mode from the sample clock.
// - External mode outputs the chosen divided data clock on the lock pin.
// - A phase strobe pulse realigns the internal divider phase.
// - Strap high selects PLL mode, ignoring the dual bit.
// - A type-4 detector compares reference and feedback clocks.
// - The prescaler divides the oscillator by 1, 2, 4 or 8.
// - Sample clock divides by 2 to 16; choice picks feedback clock.
// - Interpolation rate is sample clock over feedback clock.
// - In PLL mode the lock pin shows the lock state.
// - Strap low and dual bit set select dual clock mode.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dcg_consts.vh"

module dcg_clock_gen (
    input wire hclk, // System clock, 100 MHz.
    input wire hresetn, // Asynchronous reset, active low.
    input wire hsel, // AHB slave select.
    input wire [31:0] haddr, // AHB address.
    input wire [1:0] htrans, // AHB transfer type.
    input wire hwrite, // AHB write flag.
    input wire [2:0] hsize, // AHB transfer size.
    input wire [31:0] hwdata, // AHB write data.
    input wire hready, // AHB bus ready.
    output reg [31:0] hrdata, // AHB read data.
    output reg hreadyout, // AHB slave ready.
    output reg hresp, // AHB response, always OKAY.
    input wire pll_supply_strap, // High when the PLL supply is powered.
    input wire sample_clock_in, // Sample-rate clock level.
    input wire reference_clock_in, // Data-rate reference clock level.
    input wire vco_clock_in, // Oscillator output level.
    input wire phase_strobe_in, // Divider alignment strobe.
    output reg lock_or_data_clock_out, // Data clock, lock flag or low.
    output reg sample_rate_clock_out, // Internal sample-rate clock.
    output reg data_clock_out, // Data input clock.
    output reg [3:0] div_clocks_out, // Divide-by-2, 4, 8 and 16 clocks.
    output reg pfd_up_out, // Detector pump-up.
    output reg pfd_down_out, // Detector pump-down.
    output reg [1:0] clock_mode_out, // Current clock mode.
    output reg [4:0] interp_ratio_out // Interpolation ratio 2 to 16.
);

    // Bus and register state.
    reg [4:0] ctrl_r;
    reg [4:0] ctrl_nxt;
    reg [11:0] addr_r;
    reg wr_r;
    reg [31:0] rdata_nxt;
    wire addr_phase;

    // Clock path state.
    reg strap_r;
    reg [1:0] mode_r;
    reg [1:0] mode_nxt;
    reg sr_lvl_d_r;
    reg strobe_d_r;
    reg sr_lvl;
    reg fb_lvl;
    reg pin_nxt;
    reg [4:0] ratio_nxt;
    wire [1:0] sel;
    wire [1:0] div;
    wire dual_clk;
    wire sr_tick;
    wire vco_tick;
    wire strobe_rise;
    wire [3:0] pre_cnt;
    wire [3:0] smp_cnt;
    wire pfd_up;
    wire pfd_down;
    wire pfd_locked;
    reg vco_d_r;

    assign sel = ctrl_r[`DCG_CTRL_SEL_LSB +: 2];
    assign div = ctrl_r[`DCG_CTRL_DIV_LSB +: 2];
    assign dual_clk = ctrl_r[`DCG_CTRL_DUAL_BIT];
    assign addr_phase = hsel & hready & htrans[1];

    // Bus slave: address phase captured, write lands in the data phase.
    always @* begin
        ctrl_nxt = ctrl_r;
        if (wr_r && (addr_r == `DCG_CTRL_OFF)) begin
            ctrl_nxt = hwdata[4:0];
        end
    end

    // Read data is prepared in the address phase from the next control value.
    always @* begin
        rdata_nxt = 32'h0000_0000;
        case (haddr[11:0])
            `DCG_CTRL_OFF: begin
                rdata_nxt[4:0] = ctrl_nxt;
            end
            `DCG_STAT_OFF: begin
                rdata_nxt[`DCG_STAT_MODE_LSB +: 2] = mode_r;
                rdata_nxt[`DCG_STAT_LOCK_BIT] = pfd_locked;
                rdata_nxt[`DCG_STAT_STRAP_BIT] = strap_r;
                rdata_nxt[`DCG_STAT_RATIO_LSB +: 5] = interp_ratio_out;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `DCG_CTRL_RST;
            addr_r <= 12'h000;
            wr_r <= 1'b0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_phase) begin
                addr_r <= haddr[11:0];
                wr_r <= hwrite;
                if (!hwrite) begin
                    hrdata <= rdata_nxt;
                end
            end else begin
                wr_r <= 1'b0;
            end
        end
    end

    // Clock mode from the strap and the dual clock bit.
    always @* begin
        case ({strap_r, dual_clk})
            2'b00: begin
                mode_nxt = `DCG_MODE_EXT;
            end
            2'b01: begin
                mode_nxt = `DCG_MODE_DUAL;
            end
            2'b10, 2'b11: begin
                mode_nxt = `DCG_MODE_PLL;
            end
            default: begin
                mode_nxt = `DCG_MODE_EXT;
            end
        endcase
    end

    assign vco_tick = vco_clock_in & ~vco_d_r;

    dcg_divider u_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(vco_tick),
        .clear(mode_r != `DCG_MODE_PLL),
        .count_r(pre_cnt)
    );

    always @* begin
        if (mode_r == `DCG_MODE_PLL) begin
            case (div)
                2'h0: begin
                    sr_lvl = vco_clock_in;
                end
                2'h1: begin
                    sr_lvl = pre_cnt[0];
                end
                2'h2: begin
                    sr_lvl = pre_cnt[1];
                end
                2'h3: begin
                    sr_lvl = pre_cnt[2];
                end
                default: begin
                    sr_lvl = vco_clock_in;
                end
            endcase
        end else begin
            sr_lvl = sample_clock_in;
        end
    end

    assign sr_tick = sr_lvl & ~sr_lvl_d_r;
    assign strobe_rise = phase_strobe_in & ~strobe_d_r;

    dcg_divider u_sample_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(sr_tick),
        .clear(strobe_rise),
        .count_r(smp_cnt)
    );

    // Choice picks the feedback clock and ratio.
    always @* begin
        case (sel)
            `DCG_SEL_2X: begin
                fb_lvl = smp_cnt[0];
                ratio_nxt = 5'h02;
            end
            `DCG_SEL_4X: begin
                fb_lvl = smp_cnt[1];
                ratio_nxt = 5'h04;
            end
            `DCG_SEL_8X: begin
                fb_lvl = smp_cnt[2];
                ratio_nxt = 5'h08;
            end
            `DCG_SEL_16X: begin
                fb_lvl = smp_cnt[3];
                ratio_nxt = 5'h10;
            end
            default: begin
                fb_lvl = smp_cnt[0];
                ratio_nxt = 5'h02;
            end
        endcase
    end

    dcg_pfd u_pfd (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(mode_r == `DCG_MODE_PLL),
        .ref_lvl(reference_clock_in),
        .fb_lvl(fb_lvl),
        .up_r(pfd_up),
        .down_r(pfd_down),
        .locked_r(pfd_locked)
    );

    // Function of the lock/data clock pin per mode.
    always @* begin
        case (mode_r)
            `DCG_MODE_EXT: begin
                pin_nxt = fb_lvl;
            end
            `DCG_MODE_PLL: begin
                pin_nxt = pfd_locked;
            end
            `DCG_MODE_DUAL: begin
                pin_nxt = 1'b0;
            end
            default: begin
                pin_nxt = 1'b0;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_r <= 1'b0;
            mode_r <= `DCG_MODE_EXT;
            sr_lvl_d_r <= 1'b0;
            strobe_d_r <= 1'b0;
            vco_d_r <= 1'b0;
            lock_or_data_clock_out <= 1'b0;
            sample_rate_clock_out <= 1'b0;
            data_clock_out <= 1'b0;
            div_clocks_out <= 4'h0;
            pfd_up_out <= 1'b0;
            pfd_down_out <= 1'b0;
            clock_mode_out <= `DCG_MODE_EXT;
            interp_ratio_out <= 5'h02;
        end else begin
            strap_r <= pll_supply_strap;
            mode_r <= mode_nxt;
            sr_lvl_d_r <= sr_lvl;
            strobe_d_r <= phase_strobe_in;
            vco_d_r <= vco_clock_in;
            lock_or_data_clock_out <= pin_nxt;
            sample_rate_clock_out <= sr_lvl;
            // Dual mode data clock from reference.
            if (mode_r == `DCG_MODE_DUAL) begin
                data_clock_out <= reference_clock_in;
            end else begin
                data_clock_out <= fb_lvl;
            end
            div_clocks_out <= smp_cnt;
            pfd_up_out <= pfd_up;
            pfd_down_out <= pfd_down;
            clock_mode_out <= mode_r;
            interp_ratio_out <= ratio_nxt;
        end
    end

endmodule
`default_nettype wire

/* dcg_consts.vh */
// Constants of the DAC clock-generation block: register offsets, field
// positions, reset values, mode codes and lock-detector counts.
// Assumes inclusion by bare name from every design file of the block.
`ifndef DCG_CONSTS_VH
`define DCG_CONSTS_VH

// Register byte offsets on the AHB-Lite bus (low 12 address bits decoded).
`define DCG_CTRL_OFF 12'h000
`define DCG_STAT_OFF 12'h004

// Control register fields.
`define DCG_CTRL_SEL_LSB 0
`define DCG_CTRL_DIV_LSB 2
`define DCG_CTRL_DUAL_BIT 4
`define DCG_CTRL_RST 5'h00

// Status register fields.
`define DCG_STAT_MODE_LSB 0
`define DCG_STAT_LOCK_BIT 2
`define DCG_STAT_STRAP_BIT 3
`define DCG_STAT_RATIO_LSB 4

// Clock mode codes.
`define DCG_MODE_EXT 2'h0
`define DCG_MODE_PLL 2'h1
`define DCG_MODE_DUAL 2'h2

// Interpolation choice codes.
`define DCG_SEL_2X 2'h0
`define DCG_SEL_4X 2'h1
`define DCG_SEL_8X 2'h2
`define DCG_SEL_16X 2'h3

// Lock detector: widest accepted error pulse, good pulses needed, saturation.
`define DCG_LOCK_WIN 8'h02
`define DCG_LOCK_GOOD 4'hF
`define DCG_ERR_MAX 8'hFF

`endif

/* dcg_divider.v */
// Four-stage binary divider counting rising edges of one clock stream.
// Assumes the edge tick is one hclk cycle wide and synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
`include "dcg_consts.vh"

module dcg_divider (
    input wire hclk, // System clock.
    input wire hresetn, // Asynchronous reset, active low.
    input wire tick, // One rising edge of the divided stream.
    input wire clear, // Aligns the divider phase to zero.
    output reg [3:0] count_r // Bit k is the stream divided by 2^(k+1).
);

    reg [3:0] count_nxt;

    always @* begin
        count_nxt = count_r;
        if (clear) begin
            count_nxt = 4'h0;
        end else if (tick) begin
            count_nxt = count_r + 4'h1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= 4'h0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule
`default_nettype wire

/* dcg_pfd.v */
// Type-4 phase-frequency detector with a lock detector on its error pulses.
// Assumes reference and feedback levels are synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
`include "dcg_consts.vh"

module dcg_pfd (
    input wire hclk, // System clock.
    input wire hresetn, // Asynchronous reset, active low.
    input wire enable, // Detector runs only while set.
    input wire ref_lvl, // Reference clock level.
    input wire fb_lvl, // Feedback clock level.
    output reg up_r, // Reference leads: raise the oscillator.
    output reg down_r, // Feedback leads: lower the oscillator.
    output reg locked_r // Phase error has stayed small.
);

    reg ref_d_r;
    reg fb_d_r;
    reg [7:0] err_r;
    reg [3:0] good_r;
    wire ref_rise;
    wire fb_rise;
    wire pulse_end;

    assign ref_rise = ref_lvl & ~ref_d_r;
    assign fb_rise = fb_lvl & ~fb_d_r;
    assign pulse_end = (up_r | down_r) & ((up_r | ref_rise) & (down_r | fb_rise));

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_d_r <= 1'b0;
            fb_d_r <= 1'b0;
            up_r <= 1'b0;
            down_r <= 1'b0;
            err_r <= 8'h00;
            good_r <= 4'h0;
            locked_r <= 1'b0;
        end else if (!enable) begin
            ref_d_r <= ref_lvl;
            fb_d_r <= fb_lvl;
            up_r <= 1'b0;
            down_r <= 1'b0;
            err_r <= 8'h00;
            good_r <= 4'h0;
            locked_r <= 1'b0;
        end else begin
            ref_d_r <= ref_lvl;
            fb_d_r <= fb_lvl;
            // The other clock's edge while one state is set resets the pair.
            if (pulse_end) begin
                up_r <= 1'b0;
                down_r <= 1'b0;
                err_r <= 8'h00;
                if (err_r <= `DCG_LOCK_WIN) begin
                    if (good_r == `DCG_LOCK_GOOD) begin
                        locked_r <= 1'b1;
                    end else begin
                        good_r <= good_r + 4'h1;
                    end
                end else begin
                    good_r <= 4'h0;
                    locked_r <= 1'b0;
                end
            end else begin
                up_r <= up_r | (ref_rise & ~fb_rise);
                down_r <= down_r | (fb_rise & ~ref_rise);
                if (up_r | down_r) begin
                    if (err_r == `DCG_ERR_MAX) begin
                        good_r <= 4'h0;
                        locked_r <= 1'b0;
                    end else begin
                        err_r <= err_r + 8'h01;
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

/* dcg_clock_gen_props.sv */
// Checker of the clock-generation block, bound to its top module.
// Assumes it sees only the ports of dcg_clock_gen.
`timescale 1ns/1ps
`default_nettype none
`include "dcg_consts.vh"

module dcg_clock_gen_props (
    input wire hclk, // System clock.
    input wire hresetn, // Reset, active low.
    input wire pll_supply_strap, // Supply strap.
    input wire sample_clock_in, // Sample clock.
    input wire lock_or_data_clock_out, // Lock or data clock pin.
    input wire sample_rate_clock_out, // Sample-rate clock.
    input wire [3:0] div_clocks_out, // Divided clocks.
    input wire pfd_up_out, // Pump-up.
    input wire pfd_down_out, // Pump-down.
    input wire [1:0] clock_mode_out, // Clock mode.
    input wire [4:0] interp_ratio_out // Ratio.
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Strap reaches the mode port through three flops, so four samples are needed.
    a_strap_pll_mode: assert property (
        pll_supply_strap [*4] |-> clock_mode_out == `DCG_MODE_PLL)
        else $error("strap high but mode not PLL");
    a_strap_low_mode: assert property (
        !pll_supply_strap [*4] |-> clock_mode_out != `DCG_MODE_PLL)
        else $error("strap low but mode PLL");
    a_dual_pin_low: assert property (
        (clock_mode_out == `DCG_MODE_DUAL) [*2] |-> !lock_or_data_clock_out)
        else $error("pin not low in dual mode");
    a_pfd_idle_off: assert property (
        (clock_mode_out != `DCG_MODE_PLL) [*3] |-> !pfd_up_out && !pfd_down_out)
        else $error("detector active outside PLL mode");
    a_ratio_code_legal: assert property (
        interp_ratio_out inside {5'h02, 5'h04, 5'h08, 5'h10})
        else $error("illegal interpolation ratio");
    a_sample_clock_follow: assert property (
        ((clock_mode_out == `DCG_MODE_EXT) [*4] ##0 $rose(sample_clock_in))
        |-> ##[1:3] sample_rate_clock_out)
        else $error("sample-rate clock does not follow input");
    a_div_two_chain: assert property (
        $rose(div_clocks_out[1]) |-> !div_clocks_out[0])
        else $error("divide-by-4 rose off phase");
    a_div_sixteen_chain: assert property (
        $rose(div_clocks_out[3]) |-> div_clocks_out[2:0] == 3'h0)
        else $error("divide-by-16 rose off phase");
endmodule

bind dcg_clock_gen dcg_clock_gen_props u_props (.hclk(hclk), .hresetn(hresetn),
    .pll_supply_strap(pll_supply_strap), .sample_clock_in(sample_clock_in),
    .lock_or_data_clock_out(lock_or_data_clock_out),
    .sample_rate_clock_out(sample_rate_clock_out), .div_clocks_out(div_clocks_out),
    .pfd_up_out(pfd_up_out), .pfd_down_out(pfd_down_out),
    .clock_mode_out(clock_mode_out), .interp_ratio_out(interp_ratio_out));
`default_nettype wire

/* dcg_clock_source.sv */
// Far-side clock source: sample, reference and oscillator clock levels.
// Assumes hclk is the system clock; each clock stands still when stopped.
`timescale 1ns/1ps
`default_nettype none

module dcg_clock_source (
    input wire hclk, // System clock.
    input wire src_run, // Runs the sample clock.
    input wire ref_run, // Runs the reference clock while src_run also runs the sample clock.
    input wire vco_run, // Runs the oscillator.
    input wire echo, // Reference follows the feedback clock.
    input wire fb_in, // Feedback clock from the block.
    output var logic sample_clock_in, // Sample-rate clock.
    output wire logic reference_clock_in, // Data-rate reference.
    output var logic vco_clock_in // Oscillator level.
);
    logic ph = 1'b0;
    logic ref_r = 1'b0;
    initial sample_clock_in = 1'b0;
    initial vco_clock_in = 1'b0;
    always @(posedge hclk) begin
        ph <= ~ph;
        if (src_run && ph) begin
            sample_clock_in <= ~sample_clock_in;
            if (ref_run && !sample_clock_in) ref_r <= ~ref_r;
        end
        if (vco_run) vco_clock_in <= ~vco_clock_in;
    end
    assign reference_clock_in = echo ? fb_in : ref_r;
endmodule
`default_nettype wire

/* dcg_clock_gen_tb_top.sv */
// Self-checking bench of the clock-generation block over AHB-Lite.
// Assumes a zero-wait slave and the clock source model on the far side.
`timescale 1ns/1ps
`default_nettype none
`include "dcg_consts.vh"

module dcg_clock_gen_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic strap = 1'b0;
    logic strobe = 1'b0;
    logic src_run = 1'b0;
    logic ref_run = 1'b0;
    logic vco_run = 1'b0;
    logic echo = 1'b0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, pin, src, dck, up, dn, s_in, r_in, v_in;
    wire [3:0] div;
    wire [1:0] mode;
    wire [4:0] ratio;
    wire [4:0] mon = {dck, src, pin, dn, up};
    int miscompares = 0;
    int tests_run = 0;
    int c;

    always #5 hclk = ~hclk;

    dcg_clock_gen dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pll_supply_strap(strap), .sample_clock_in(s_in), .reference_clock_in(r_in),
        .vco_clock_in(v_in), .phase_strobe_in(strobe), .lock_or_data_clock_out(pin),
        .sample_rate_clock_out(src), .data_clock_out(dck), .div_clocks_out(div),
        .pfd_up_out(up), .pfd_down_out(dn), .clock_mode_out(mode),
        .interp_ratio_out(ratio));
    dcg_clock_source u_src (.hclk(hclk), .src_run(src_run), .ref_run(ref_run),
        .vco_run(vco_run), .echo(echo), .fb_in(dck), .sample_clock_in(s_in),
        .reference_clock_in(r_in), .vco_clock_in(v_in));

    task summarize;
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task near(input int n, input int e, input string nm);
        chk({31'h0, n >= e - 1 && n <= e + 1}, 32'h1, nm);
    endtask

    task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        chk(d, e, nm);
        chk({31'h0, hresp}, 32'h0, "hresp okay");
    endtask

    // Counts rising edges of one watched output over n cycles.
    task cnt(input int k, input int n);
        logic p;
        c = 0;
        p = mon[k];
        repeat (n) begin
            @(negedge hclk);
            if (mon[k] === 1'b1 && p === 1'b0) c++;
            p = mon[k];
        end
        @(posedge hclk);
    endtask

    task t_regs;
        rdchk(`DCG_CTRL_OFF, 32'h0, "ctrl reset");
        rdchk(`DCG_STAT_OFF, 32'h20, "stat reset");
        wr(12'h008, 32'hFFFFFFFF);
        rdchk(12'h008, 32'h0, "unmapped");
        wr(`DCG_CTRL_OFF, 32'hFFFFFFFF);
        rdchk(`DCG_CTRL_OFF, 32'h1F, "ctrl fields");
    endtask

    task t_ext;
        src_run <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(`DCG_CTRL_OFF, 32'(s));
            repeat (4) @(posedge hclk);
            rdchk(`DCG_STAT_OFF, (32'h2 << s) << 4, "ext stat");
            chk({27'h0, ratio}, 32'h2 << s, "ratio");
            cnt(2, 256);
            near(c, 32 >> s, "pin clock");
            cnt(4, 256);
            near(c, 32 >> s, "data clock");
            cnt(3, 256);
            near(c, 64, "sample-rate clock");
        end
    endtask

    task t_strobe;
        // Stop the source at a known count so the divider is surely non-zero.
        while (div !== 4'h4) @(posedge hclk);
        src_run <= 1'b0;
        repeat (6) @(posedge hclk);
        chk({31'h0, div !== 4'h0}, 32'h1, "div before strobe");
        strobe <= 1'b1;
        repeat (4) @(posedge hclk);
        strobe <= 1'b0;
        chk({28'h0, div}, 32'h0, "div after strobe");
    endtask

    task t_dual;
        wr(`DCG_CTRL_OFF, 32'h10);
        src_run <= 1'b1;
        ref_run <= 1'b1;
        repeat (6) @(posedge hclk);
        rdchk(`DCG_STAT_OFF, 32'h22, "dual stat");
        cnt(2, 256);
        chk(c, 0, "dual pin");
        cnt(4, 256);
        near(c, 32, "dual data clock");
    endtask

    task t_pll;
        src_run <= 1'b0;
        ref_run <= 1'b0;
        vco_run <= 1'b1;
        strap <= 1'b1;
        repeat (200) @(posedge hclk);
        rdchk(`DCG_STAT_OFF, 32'h29, "pll stat");
        cnt(0, 200);
        chk(c, 0, "pump-up idle ref");
        // With no reference edge the pump-down pulse stays high and never ends.
        cnt(1, 200);
        chk(c, 0, "pump-down no new edge");
        chk({31'h0, dn}, 32'h1, "pump-down idle ref");
        chk({31'h0, pin}, 32'h0, "unlocked pin");
        echo <= 1'b1;
        repeat (400) @(posedge hclk);
        rdchk(`DCG_STAT_OFF, 32'h2D, "locked stat");
        chk({31'h0, pin}, 32'h1, "locked pin");
        for (int d = 0; d < 4; d++) begin
            wr(`DCG_CTRL_OFF, 32'h10 | 32'(d << 2));
            repeat (16) @(posedge hclk);
            cnt(3, 128);
            near(c, 64 >> d, "prescaler");
        end
    endtask

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_ext();
        t_strobe();
        t_dual();
        t_pll();
        summarize();
    end

    initial begin
        #300000;
        miscompares++;
        summarize();
    end
endmodule
`default_nettype wire
